// ==== rtl/pmia_bank.sv ====
module pmia_bank (
  // Clock and reset
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_N_IN,
  // Management register port
  input  wire logic [4:0]  REG_ADDR_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  input  wire logic [15:0] REG_WDATA_IN,
  output logic      [15:0] REG_RDATA_OUT,
  output logic             REG_RVALID_OUT,
  // Strap pins
  input  wire logic [5:0]  MODEL_PINS_IN,
  // Live status from the PHY core
  input  wire logic [15:0] LINK_STAT_IN,
  input  wire logic [15:0] MSE_IN,
  input  wire logic [15:0] PCS_STAT_IN,
  input  wire logic [15:0] AN_LP_L_IN,
  input  wire logic [15:0] AN_LP_M_IN,
  input  wire logic [15:0] AN_LP_H_IN
);
  logic [15:0] ctrl_reg;
  logic [15:0] window_reg;
  logic [15:0] addr_pma_reg;
  logic [15:0] addr_pcs_reg;
  logic [15:0] addr_an_reg;
  logic [15:0] addr_oth_reg;
  logic [5:0]  model_reg;
  logic        strap_done_reg;
  logic [15:0] wr_regs [pmia_pkg::NWR];

  logic [1:0]  func;
  logic [4:0]  devad;
  logic [15:0] cur_addr;
  logic        win_wr;
  logic        win_rd;
  logic        data_mode;
  logic        do_inc;
  logic [3:0]  slot;
  logic [15:0] mmd_rdata;
  logic [15:0] next_addr;

  assign func  = ctrl_reg[pmia_pkg::CTRL_FUNC_HI:pmia_pkg::CTRL_FUNC_LO];
  assign devad = ctrl_reg[pmia_pkg::CTRL_DEVAD_HI:0];
  assign win_wr = REG_WR_IN && (REG_ADDR_IN == pmia_pkg::OFS_WINDOW);
  assign win_rd = REG_RD_IN && (REG_ADDR_IN == pmia_pkg::OFS_WINDOW);
  assign data_mode = (func != pmia_pkg::FUNC_ADDR);
  // Increment policy per function
  assign do_inc = (win_wr && (func == pmia_pkg::FUNC_DATA_INC_RW ||
                              func == pmia_pkg::FUNC_DATA_INC_W)) ||
                  (win_rd && func == pmia_pkg::FUNC_DATA_INC_RW);
  // Pointer wraps at the top of the 16-bit space
  assign next_addr = data_mode ? 16'(cur_addr + 16'h0001) : REG_WDATA_IN;

  // Per-MMD stored address lookup
  always_comb begin
    case (devad)
      pmia_pkg::DEVAD_PMA: cur_addr = addr_pma_reg;
      pmia_pkg::DEVAD_PCS: cur_addr = addr_pcs_reg;
      pmia_pkg::DEVAD_AN:  cur_addr = addr_an_reg;
      default:             cur_addr = addr_oth_reg;
    endcase
  end

  // Map (devad, address) onto a writable slot
  function automatic logic [3:0] wslot(input logic [4:0] d, input logic [15:0] a);
    logic [3:0] s;
    s = 4'(pmia_pkg::NO_SLOT);
    if (d == pmia_pkg::DEVAD_PMA) begin
      case (a)
        pmia_pkg::A_CTRL1: s = 4'(pmia_pkg::W_PMA_CTRL1);
        pmia_pkg::A_CTRL2: s = 4'(pmia_pkg::W_PMA_CTRL2);
        pmia_pkg::A_TXDIS: s = 4'(pmia_pkg::W_PMA_TXDIS);
        pmia_pkg::A_BT1CT: s = 4'(pmia_pkg::W_BT1_CT);
        pmia_pkg::A_LRPC:  s = 4'(pmia_pkg::W_LR_PC);
        pmia_pkg::A_LRTM:  s = 4'(pmia_pkg::W_LR_TM);
        default:           s = 4'(pmia_pkg::NO_SLOT);
      endcase
    end else if (d == pmia_pkg::DEVAD_PCS) begin
      case (a)
        pmia_pkg::A_CTRL1: s = 4'(pmia_pkg::W_PCS_CTRL1);
        pmia_pkg::A_LRCC:  s = 4'(pmia_pkg::W_LR_CC);
        default:           s = 4'(pmia_pkg::NO_SLOT);
      endcase
    end else if (d == pmia_pkg::DEVAD_AN) begin
      case (a)
        pmia_pkg::A_ANCT: s = 4'(pmia_pkg::W_AN_CT);
        pmia_pkg::A_ADVL: s = 4'(pmia_pkg::W_ADV_L);
        pmia_pkg::A_ADVM: s = 4'(pmia_pkg::W_ADV_M);
        pmia_pkg::A_ADVH: s = 4'(pmia_pkg::W_ADV_H);
        pmia_pkg::A_NPL:  s = 4'(pmia_pkg::W_NP_L);
        pmia_pkg::A_NPM:  s = 4'(pmia_pkg::W_NP_M);
        default:          s = 4'(pmia_pkg::NO_SLOT);
      endcase
    end
    return s;
  endfunction

  function automatic logic [15:0] wreset(input int i);
    logic [15:0] v;
    v = 16'h0000;
    case (i)
      pmia_pkg::W_PMA_CTRL1: v = pmia_pkg::R_PMA_CTRL1;
      pmia_pkg::W_PMA_CTRL2: v = pmia_pkg::R_PMA_CTRL2;
      pmia_pkg::W_PMA_TXDIS: v = pmia_pkg::R_PMA_TXDIS;
      pmia_pkg::W_BT1_CT:    v = pmia_pkg::R_BT1_CT;
      pmia_pkg::W_LR_PC:     v = pmia_pkg::R_LR_PC;
      pmia_pkg::W_LR_TM:     v = pmia_pkg::R_LR_TM;
      pmia_pkg::W_PCS_CTRL1: v = pmia_pkg::R_PCS_CTRL1;
      pmia_pkg::W_LR_CC:     v = pmia_pkg::R_LR_CC;
      pmia_pkg::W_AN_CT:     v = pmia_pkg::R_AN_CT;
      pmia_pkg::W_ADV_L:     v = pmia_pkg::R_ADV_L;
      pmia_pkg::W_ADV_M:     v = pmia_pkg::R_ADV_M;
      pmia_pkg::W_ADV_H:     v = pmia_pkg::R_ADV_H;
      pmia_pkg::W_NP_L:      v = pmia_pkg::R_NP_L;
      pmia_pkg::W_NP_M:      v = pmia_pkg::R_NP_M;
      default:               v = 16'h0000;
    endcase
    return v;
  endfunction

  assign slot = wslot(devad, cur_addr);

  // MMD read decode
  always_comb begin
    mmd_rdata = 16'h0000;
    if (slot != 4'(pmia_pkg::NO_SLOT)) begin
      mmd_rdata = wr_regs[slot];
    end else if (devad == pmia_pkg::DEVAD_PMA) begin
      case (cur_addr)
        pmia_pkg::A_STAT1: mmd_rdata = pmia_pkg::R_PMA_STAT1;
        pmia_pkg::A_DEVL:  mmd_rdata = pmia_pkg::DEVS_LOW;
        pmia_pkg::A_DEVH:  mmd_rdata = pmia_pkg::DEVS_HIGH;
        pmia_pkg::A_STAT2: mmd_rdata = pmia_pkg::R_PMA_STAT2;
        pmia_pkg::A_EXTAB: mmd_rdata = pmia_pkg::R_PMA_EXTAB;
        pmia_pkg::A_BT1AB: mmd_rdata = pmia_pkg::R_BT1_AB;
        pmia_pkg::A_LRPS:  mmd_rdata = pmia_pkg::R_LR_PS;
        pmia_pkg::A_LRLS:  mmd_rdata = LINK_STAT_IN;
        pmia_pkg::A_MSE:   mmd_rdata = MSE_IN;
        default:           mmd_rdata = 16'h0000;
      endcase
    end else if (devad == pmia_pkg::DEVAD_PCS) begin
      case (cur_addr)
        pmia_pkg::A_STAT1: mmd_rdata = pmia_pkg::R_PCS_STATUS_ONE;
        pmia_pkg::A_DEVL:  mmd_rdata = pmia_pkg::DEVS_LOW;
        pmia_pkg::A_DEVH:  mmd_rdata = pmia_pkg::DEVS_HIGH;
        pmia_pkg::A_STAT2: mmd_rdata = pmia_pkg::R_PCS_STATUS_TWO;
        pmia_pkg::A_LRCS:  mmd_rdata = PCS_STAT_IN;
        default:           mmd_rdata = 16'h0000;
      endcase
    end else if (devad == pmia_pkg::DEVAD_AN) begin
      case (cur_addr)
        pmia_pkg::A_DEVL: mmd_rdata = pmia_pkg::DEVS_LOW;
        pmia_pkg::A_DEVH: mmd_rdata = pmia_pkg::DEVS_HIGH;
        pmia_pkg::A_ANST: mmd_rdata = pmia_pkg::R_AN_ST;
        pmia_pkg::A_LPL:  mmd_rdata = AN_LP_L_IN;
        pmia_pkg::A_LPM:  mmd_rdata = AN_LP_M_IN;
        pmia_pkg::A_LPH:  mmd_rdata = AN_LP_H_IN;
        default:          mmd_rdata = 16'h0000;
      endcase
    end
  end

  // Control register; reserved bits never stored
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      ctrl_reg <= pmia_pkg::CTRL_RESET;
    end else if (REG_WR_IN && REG_ADDR_IN == pmia_pkg::OFS_CTRL) begin
      ctrl_reg <= {REG_WDATA_IN[15:14], 9'h000, REG_WDATA_IN[4:0]};
    end
  end

  // Window shadow holds the last value written
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      window_reg <= pmia_pkg::WINDOW_RESET;
    end else if (win_wr) begin
      window_reg <= REG_WDATA_IN;
    end
  end

  // Per-MMD address pointers
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      addr_pma_reg <= 16'h0000;
      addr_pcs_reg <= 16'h0000;
      addr_an_reg  <= 16'h0000;
      addr_oth_reg <= 16'h0000;
    end else if ((win_wr && !data_mode) || do_inc) begin
      case (devad)
        pmia_pkg::DEVAD_PMA: addr_pma_reg <= next_addr;
        pmia_pkg::DEVAD_PCS: addr_pcs_reg <= next_addr;
        pmia_pkg::DEVAD_AN:  addr_an_reg  <= next_addr;
        default:             addr_oth_reg <= next_addr;
      endcase
    end
  end

  // Writable MMD registers; writes elsewhere are dropped
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < pmia_pkg::NWR; i++) begin
        wr_regs[i] <= wreset(i);
      end
    end else if (win_wr && data_mode && slot != 4'(pmia_pkg::NO_SLOT)) begin
      wr_regs[slot] <= REG_WDATA_IN;
    end
  end

  // Model strap caught after reset release
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      strap_done_reg <= 1'b0;
      model_reg      <= 6'h00;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      model_reg      <= MODEL_PINS_IN;
    end
  end

  // Registered read data
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      REG_RDATA_OUT  <= 16'h0000;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_RD_IN;
      if (REG_RD_IN) begin
        case (REG_ADDR_IN)
          pmia_pkg::OFS_IDENT:
            REG_RDATA_OUT <= {pmia_pkg::ORG_ID_BITS, model_reg,
                              pmia_pkg::REVISION_NUMBER};
          pmia_pkg::OFS_CTRL:   REG_RDATA_OUT <= ctrl_reg;
          pmia_pkg::OFS_WINDOW: REG_RDATA_OUT <= data_mode ? mmd_rdata : cur_addr;
          default:              REG_RDATA_OUT <= 16'h0000;
        endcase
      end
    end
  end

  ctrl_reserved_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    ctrl_reg[13:5] == 9'h000) else $error("reserved control bits set");

  addr_load_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    win_wr && func == pmia_pkg::FUNC_ADDR && !(REG_WR_IN && REG_ADDR_IN == pmia_pkg::OFS_CTRL)
    |=> cur_addr == $past(REG_WDATA_IN)) else $error("address not loaded");

  no_inc_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (win_wr || win_rd) && func == pmia_pkg::FUNC_DATA |=> $stable(cur_addr))
    else $error("address moved without increment");

  inc_rw_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    win_rd && func == pmia_pkg::FUNC_DATA_INC_RW && !REG_WR_IN
    |=> cur_addr == $past(cur_addr) + 16'h0001) else $error("read did not increment");

  inc_w_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    win_rd && func == pmia_pkg::FUNC_DATA_INC_W && !REG_WR_IN |=> $stable(cur_addr))
    else $error("read incremented in write-only mode");

  ident_org_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    REG_RD_IN && REG_ADDR_IN == pmia_pkg::OFS_IDENT
    |=> REG_RVALID_OUT && REG_RDATA_OUT[15:10] == pmia_pkg::ORG_ID_BITS)
    else $error("identifier bits wrong");

  ro_write_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    win_wr && data_mode && slot == 4'(pmia_pkg::NO_SLOT) |=> $stable(wr_regs[0]))
    else $error("read-only write stored");

  devs_high_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    data_mode && cur_addr == pmia_pkg::A_DEVH && (devad == pmia_pkg::DEVAD_AN)
    |-> mmd_rdata == pmia_pkg::DEVS_HIGH) else $error("devices high word wrong");

  devs_low_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    data_mode && cur_addr == pmia_pkg::A_DEVL && devad == pmia_pkg::DEVAD_PMA
    |-> mmd_rdata == pmia_pkg::DEVS_LOW) else $error("devices low word wrong");

  unmapped_zero_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    devad != pmia_pkg::DEVAD_PMA && devad != pmia_pkg::DEVAD_PCS && devad != pmia_pkg::DEVAD_AN
    |-> mmd_rdata == 16'h0000) else $error("unmapped device returned data");

  window_shadow_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    win_wr |=> window_reg == $past(REG_WDATA_IN)) else $error("window shadow not loaded");

  ctrl_write_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    REG_WR_IN && REG_ADDR_IN == pmia_pkg::OFS_CTRL
    |=> ctrl_reg == ($past(REG_WDATA_IN) & 16'hc01f)) else $error("control write lost");

  route_split_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (win_wr || win_rd) && devad == pmia_pkg::DEVAD_PMA
    |=> $stable(addr_pcs_reg) && $stable(addr_an_reg)) else $error("other pointer moved");

  rvalid_pulse_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    REG_RD_IN |=> REG_RVALID_OUT) else $error("read not answered");

  rvalid_idle_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    !REG_RD_IN |=> !REG_RVALID_OUT) else $error("answer without read");

  rdata_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    !REG_RD_IN |=> $stable(REG_RDATA_OUT)) else $error("read data changed without read");

  strap_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    strap_done_reg |=> $stable(model_reg)) else $error("model strap recaptured");

  ident_rev_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    REG_RD_IN && REG_ADDR_IN == pmia_pkg::OFS_IDENT
    |=> REG_RDATA_OUT[3:0] == pmia_pkg::REVISION_NUMBER) else $error("revision bits wrong");
endmodule

// ==== rtl/pmia_pkg.sv ====
// Contract
// - Bits [15:14] pick the window function; 00 makes a window write load the address.
// - Function 01 reaches data on window reads and writes and keeps the address.
// - Function 10 advances the address after every window read or write of data.
// - Function 11 advances the address after a window write only; reads leave it alone.
// - Bits [4:0] route each window access to the named MMD; the host sets them first.
// - The 16-bit read/write window plus the control register is the path into MMD space.
// - Control and window reset to zero and control bits [13:5] read as zero.
// - The identifier word is read-only with six organisation id bits in [15:10].
// - Identifier holds a read-only pin-set model number in [9:4] and revision in [3:0].
// - MMD 0x01 is PMA/PMD, 0x03 PCS and 0x07 autonegotiation, each with its own registers.
// - Every implemented MMD reports devices-in-package low 0x008b and high 0xc000.
package pmia_pkg;
  localparam logic [4:0]  OFS_IDENT        = 5'h03;
  localparam logic [4:0]  OFS_CTRL         = 5'h0d;
  localparam logic [4:0]  OFS_WINDOW       = 5'h0e;
  localparam int          CTRL_FUNC_HI     = 15;
  localparam int          CTRL_FUNC_LO     = 14;
  localparam int          CTRL_DEVAD_HI    = 4;
  localparam logic [15:0] CTRL_RESET       = 16'h0000;
  localparam logic [15:0] WINDOW_RESET     = 16'h0000;
  localparam logic [1:0]  FUNC_ADDR        = 2'h0;
  localparam logic [1:0]  FUNC_DATA        = 2'h1;
  localparam logic [1:0]  FUNC_DATA_INC_RW = 2'h2;
  localparam logic [1:0]  FUNC_DATA_INC_W  = 2'h3;
  localparam logic [4:0]  DEVAD_PMA        = 5'h01;
  localparam logic [4:0]  DEVAD_PCS        = 5'h03;
  localparam logic [4:0]  DEVAD_AN         = 5'h07;
  // Arbitrary neutral identity values
  localparam logic [5:0]  ORG_ID_BITS      = 6'h15;
  localparam logic [3:0]  REVISION_NUMBER  = 4'h3;
  localparam logic [15:0] DEVS_LOW         = 16'h008b;
  localparam logic [15:0] DEVS_HIGH        = 16'hc000;
  // MMD register addresses
  localparam logic [15:0] A_CTRL1 = 16'h0000;
  localparam logic [15:0] A_STAT1 = 16'h0001;
  localparam logic [15:0] A_DEVL  = 16'h0005;
  localparam logic [15:0] A_DEVH  = 16'h0006;
  localparam logic [15:0] A_CTRL2 = 16'h0007;
  localparam logic [15:0] A_STAT2 = 16'h0008;
  localparam logic [15:0] A_TXDIS = 16'h0009;
  localparam logic [15:0] A_EXTAB = 16'h000b;
  localparam logic [15:0] A_BT1AB = 16'h0012;
  localparam logic [15:0] A_BT1CT = 16'h0834;
  localparam logic [15:0] A_LRPC  = 16'h08f6;
  localparam logic [15:0] A_LRPS  = 16'h08f7;
  localparam logic [15:0] A_LRTM  = 16'h08f8;
  localparam logic [15:0] A_LRLS  = 16'h8302;
  localparam logic [15:0] A_MSE   = 16'h830b;
  localparam logic [15:0] A_LRCC  = 16'h08e6;
  localparam logic [15:0] A_LRCS  = 16'h08e7;
  localparam logic [15:0] A_ANCT  = 16'h0200;
  localparam logic [15:0] A_ANST  = 16'h0201;
  localparam logic [15:0] A_ADVL  = 16'h0202;
  localparam logic [15:0] A_ADVM  = 16'h0203;
  localparam logic [15:0] A_ADVH  = 16'h0204;
  localparam logic [15:0] A_LPL   = 16'h0205;
  localparam logic [15:0] A_LPM   = 16'h0206;
  localparam logic [15:0] A_LPH   = 16'h0207;
  localparam logic [15:0] A_NPL   = 16'h0208;
  localparam logic [15:0] A_NPM   = 16'h0209;
  // Reset values
  localparam logic [15:0] R_PMA_CTRL1 = 16'h0000;
  localparam logic [15:0] R_PMA_STAT1 = 16'h0002;
  localparam logic [15:0] R_PMA_CTRL2 = 16'h003d;
  localparam logic [15:0] R_PMA_STAT2 = 16'h8301;
  localparam logic [15:0] R_PMA_TXDIS = 16'h0000;
  localparam logic [15:0] R_PMA_EXTAB = 16'h0800;
  localparam logic [15:0] R_BT1_AB    = 16'h0004;
  localparam logic [15:0] R_BT1_CT    = 16'h8002;
  localparam logic [15:0] R_LR_PC     = 16'h0000;
  localparam logic [15:0] R_LR_PS     = 16'h2800;
  localparam logic [15:0] R_LR_TM     = 16'h0000;
  localparam logic [15:0] R_PCS_CTRL1 = 16'h0000;
  localparam logic [15:0] R_PCS_STATUS_ONE = 16'h0002;
  localparam logic [15:0] R_PCS_STATUS_TWO = 16'h8000;
  localparam logic [15:0] R_LR_CC     = 16'h0000;
  localparam logic [15:0] R_AN_CT     = 16'h1000;
  localparam logic [15:0] R_AN_ST     = 16'h0008;
  localparam logic [15:0] R_ADV_L     = 16'h0001;
  localparam logic [15:0] R_ADV_M     = 16'h4000;
  localparam logic [15:0] R_ADV_H     = 16'h0000;
  localparam logic [15:0] R_NP_L      = 16'h2001;
  localparam logic [15:0] R_NP_M      = 16'h0000;
  // Writable register slots
  localparam int W_PMA_CTRL1 = 0;
  localparam int W_PMA_CTRL2 = 1;
  localparam int W_PMA_TXDIS = 2;
  localparam int W_BT1_CT    = 3;
  localparam int W_LR_PC     = 4;
  localparam int W_LR_TM     = 5;
  localparam int W_PCS_CTRL1 = 6;
  localparam int W_LR_CC     = 7;
  localparam int W_AN_CT     = 8;
  localparam int W_ADV_L     = 9;
  localparam int W_ADV_M     = 10;
  localparam int W_ADV_H     = 11;
  localparam int W_NP_L      = 12;
  localparam int W_NP_M      = 13;
  localparam int NWR         = 14;
  localparam int NO_SLOT     = 15;
endpackage

// ==== tb/pmia_host_model.sv ====
module pmia_host_model (
  // Clock
  input  wire logic        clk_in,
  // Answer from the bank
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in,
  // Request to the bank
  output logic      [4:0]  addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [15:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr_out  = 5'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 16'h0000;
  end

  // Released lines carry the inverse so stale values never pass as good
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask

  // Answer sampled in the one cycle it stands
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    #1;
    v = rvalid_in;
    d = rdata_in;
  endtask

  // Device address always set before the window is touched
  task automatic set_ptr(input logic [4:0] dv, input logic [15:0] ra);
    wr(pmia_pkg::OFS_CTRL, {pmia_pkg::FUNC_ADDR, 9'h000, dv});
    wr(pmia_pkg::OFS_WINDOW, ra);
  endtask
endmodule

// ==== tb/tb_pmia_bank.sv ====
module tb_pmia_bank;
  timeunit 1ns;
  timeprecision 1ps;
  `define PMIA_CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("mismatch at %0t got %h expected %h", $time, (g), (e)); end end

  localparam logic [4:0] WIN = pmia_pkg::OFS_WINDOW;
  localparam logic [4:0] PMA = pmia_pkg::DEVAD_PMA;
  localparam logic [4:0] PCS = pmia_pkg::DEVAD_PCS;
  localparam logic [4:0] AN  = pmia_pkg::DEVAD_AN;
  localparam logic [15:0] ID_A = {pmia_pkg::ORG_ID_BITS, 6'h2a, pmia_pkg::REVISION_NUMBER};
  localparam logic [15:0] ID_B = {pmia_pkg::ORG_ID_BITS, 6'h15, pmia_pkg::REVISION_NUMBER};
  // Device address, register address, reset value
  localparam logic [39:0] MAP [28] = '{
    40'h01_0000_0000, 40'h01_0001_0002, 40'h01_0005_008b, 40'h01_0006_c000,
    40'h01_0007_003d, 40'h01_0008_8301, 40'h01_0009_0000, 40'h01_000b_0800,
    40'h01_0012_0004, 40'h01_0834_8002, 40'h01_08f6_0000, 40'h01_08f7_2800,
    40'h01_08f8_0000, 40'h03_0000_0000, 40'h03_0001_0002, 40'h03_0005_008b,
    40'h03_0006_c000, 40'h03_0008_8000, 40'h03_08e6_0000, 40'h07_0005_008b,
    40'h07_0006_c000, 40'h07_0200_1000, 40'h07_0201_0008, 40'h07_0202_0001,
    40'h07_0203_4000, 40'h07_0204_0000, 40'h07_0208_2001, 40'h07_0209_0000};

  logic        SYS_CLK_IN;
  logic        RST_N_IN;
  logic [4:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic [5:0]  model_pins;
  logic [15:0] live [6];
  int          failures;
  int          samples_checked;

  pmia_bank dut_u (
    .SYS_CLK_IN     (SYS_CLK_IN),
    .RST_N_IN       (RST_N_IN),
    .REG_ADDR_IN    (reg_addr),
    .REG_WR_IN      (reg_wr),
    .REG_RD_IN      (reg_rd),
    .REG_WDATA_IN   (reg_wdata),
    .REG_RDATA_OUT  (reg_rdata),
    .REG_RVALID_OUT (reg_rvalid),
    .MODEL_PINS_IN  (model_pins),
    .LINK_STAT_IN   (live[0]),
    .MSE_IN         (live[1]),
    .PCS_STAT_IN    (live[2]),
    .AN_LP_L_IN     (live[3]),
    .AN_LP_M_IN     (live[4]),
    .AN_LP_H_IN     (live[5])
  );

  pmia_host_model host_u (
    .clk_in    (SYS_CLK_IN),
    .rdata_in  (reg_rdata),
    .rvalid_in (reg_rvalid),
    .addr_out  (reg_addr),
    .wr_out    (reg_wr),
    .rd_out    (reg_rd),
    .wdata_out (reg_wdata)
  );

  initial begin
    SYS_CLK_IN = 1'b0;
    forever #2.5 SYS_CLK_IN = ~SYS_CLK_IN;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    host_u.rd(a, d, v);
    `PMIA_CHK(v, 1'b1)
    `PMIA_CHK(d, e)
  endtask

  task automatic ctrl(input logic [1:0] f, input logic [4:0] dv);
    host_u.wr(pmia_pkg::OFS_CTRL, {f, 9'h000, dv});
  endtask

  task automatic mchk(input logic [4:0] dv, input logic [15:0] ra, input logic [15:0] e);
    host_u.set_ptr(dv, ra);
    ctrl(pmia_pkg::FUNC_DATA, dv);
    rchk(WIN, e);
  endtask

  task automatic mwr(input logic [4:0] dv, input logic [15:0] ra, input logic [15:0] d);
    host_u.set_ptr(dv, ra);
    ctrl(pmia_pkg::FUNC_DATA, dv);
    host_u.wr(WIN, d);
  endtask

  // Window read in address mode shows the stored pointer
  task automatic pchk(input logic [4:0] dv, input logic [15:0] e);
    ctrl(pmia_pkg::FUNC_ADDR, dv);
    rchk(WIN, e);
  endtask

  task automatic t_reset();
    rchk(pmia_pkg::OFS_CTRL, pmia_pkg::CTRL_RESET);
    rchk(WIN, pmia_pkg::WINDOW_RESET);
    rchk(pmia_pkg::OFS_IDENT, ID_A);
    host_u.wr(pmia_pkg::OFS_IDENT, 16'h0000);
    rchk(pmia_pkg::OFS_IDENT, ID_A);
    host_u.wr(pmia_pkg::OFS_CTRL, 16'hffff);
    rchk(pmia_pkg::OFS_CTRL, 16'hc01f);
    $display("test reset_and_ident done");
  endtask

  task automatic t_map();
    foreach (MAP[i]) begin
      mchk(MAP[i][36:32], MAP[i][31:16], MAP[i][15:0]);
    end
    $display("test mmd_map done");
  endtask

  task automatic t_incr();
    host_u.set_ptr(AN, pmia_pkg::A_ANCT);
    ctrl(pmia_pkg::FUNC_DATA_INC_RW, AN);
    rchk(WIN, pmia_pkg::R_AN_CT);
    rchk(WIN, pmia_pkg::R_AN_ST);
    host_u.wr(WIN, 16'h1234);
    host_u.wr(WIN, 16'h5678);
    pchk(AN, 16'h0204);
    mchk(AN, pmia_pkg::A_ADVL, 16'h1234);
    mchk(AN, pmia_pkg::A_ADVM, 16'h5678);
    host_u.set_ptr(AN, 16'hffff);
    pchk(AN, 16'hffff);
    ctrl(pmia_pkg::FUNC_DATA_INC_RW, AN);
    rchk(WIN, 16'h0000);
    pchk(AN, 16'h0000);
    $display("test post_increment done");
  endtask

  task automatic t_wr_only();
    host_u.set_ptr(AN, pmia_pkg::A_NPL);
    ctrl(pmia_pkg::FUNC_DATA_INC_W, AN);
    rchk(WIN, pmia_pkg::R_NP_L);
    rchk(WIN, pmia_pkg::R_NP_L);
    pchk(AN, pmia_pkg::A_NPL);
    ctrl(pmia_pkg::FUNC_DATA_INC_W, AN);
    host_u.wr(WIN, 16'h00aa);
    pchk(AN, pmia_pkg::A_NPM);
    mchk(AN, pmia_pkg::A_NPL, 16'h00aa);
    $display("test increment_on_write done");
  endtask

  task automatic t_data();
    host_u.set_ptr(PMA, pmia_pkg::A_CTRL2);
    host_u.set_ptr(PCS, pmia_pkg::A_LRCC);
    ctrl(pmia_pkg::FUNC_DATA, PMA);
    host_u.wr(WIN, 16'h0123);
    rchk(WIN, 16'h0123);
    pchk(PMA, pmia_pkg::A_CTRL2);
    pchk(PCS, pmia_pkg::A_LRCC);
    mchk(PCS, pmia_pkg::A_LRCC, pmia_pkg::R_LR_CC);
    $display("test data_no_increment done");
  endtask

  task automatic t_readonly();
    mwr(PMA, pmia_pkg::A_STAT1, 16'hffff);
    mchk(PMA, pmia_pkg::A_STAT1, pmia_pkg::R_PMA_STAT1);
    mwr(PCS, pmia_pkg::A_DEVL, 16'h0000);
    mchk(PCS, pmia_pkg::A_DEVL, pmia_pkg::DEVS_LOW);
    @(posedge SYS_CLK_IN);
    for (int i = 0; i < 6; i++) begin
      live[i] <= 16'h1010 * 16'(i + 1) + 16'h0005;
    end
    mwr(PMA, pmia_pkg::A_LRLS, 16'h5555);
    mchk(PMA, pmia_pkg::A_LRLS, 16'h1015);
    mchk(PMA, pmia_pkg::A_MSE, 16'h2025);
    mchk(PCS, pmia_pkg::A_LRCS, 16'h3035);
    mchk(AN, pmia_pkg::A_LPL, 16'h4045);
    mchk(AN, pmia_pkg::A_LPM, 16'h5055);
    mchk(AN, pmia_pkg::A_LPH, 16'h6065);
    mchk(5'h05, pmia_pkg::A_DEVL, 16'h0000);
    $display("test read_only_and_live done");
  endtask

  // Mid-run reset: written state back to defaults, straps caught once more
  task automatic t_rerun();
    @(posedge SYS_CLK_IN);
    RST_N_IN   <= 1'b0;
    model_pins <= 6'h15;
    repeat (2) @(posedge SYS_CLK_IN);
    RST_N_IN <= 1'b1;
    rchk(pmia_pkg::OFS_CTRL, pmia_pkg::CTRL_RESET);
    rchk(pmia_pkg::OFS_IDENT, ID_B);
    @(posedge SYS_CLK_IN);
    model_pins <= 6'h3f;
    rchk(pmia_pkg::OFS_IDENT, ID_B);
    pchk(AN, 16'h0000);
    mchk(AN, pmia_pkg::A_ADVL, pmia_pkg::R_ADV_L);
    mchk(PMA, pmia_pkg::A_CTRL2, pmia_pkg::R_PMA_CTRL2);
    $display("test midrun_reset done");
  endtask

  initial begin
    failures = 0;
    samples_checked = 0;
    RST_N_IN = 1'b0;
    model_pins = 6'h2a;
    for (int i = 0; i < 6; i++) begin
      live[i] = 16'h0000;
    end
    repeat (8) @(posedge SYS_CLK_IN);
    RST_N_IN <= 1'b1;
    repeat (2) @(posedge SYS_CLK_IN);
    t_reset();
    t_map();
    t_incr();
    t_wr_only();
    t_data();
    t_readonly();
    t_rerun();
    end_of_test();
  end

  // Whole run needs about five hundred cycles
  initial begin
    repeat (20000) @(posedge SYS_CLK_IN);
    failures++;
    end_of_test();
  end
endmodule
